// ### design/ebc_area_config.sv
// external bus area configuration registers and per-access decode
`timescale 1ns/1ps
`default_nettype none
`include "ebc_params.svh"
module ebc_area_config
   import ebc_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // standby pins
   input wire logic HW_STANDBY,
   input wire logic SW_STANDBY,
   // register port
   input wire logic [`EBC_ADDR_W-1:0] ADDR,
   input wire logic [7:0] WR_DATA,
   input wire logic WR_EN,
   input wire logic RD_EN,
   output logic [7:0] RD_DATA,
   // access query from the bus cycle logic
   input wire ebc_acc_req_s ACC_REQ,
   output ebc_acc_rsp_s ACC_RSP,
   // static configuration
   input wire logic REQUEST_OUT_PIN_SELECT,
   output ebc_cfg_s CFG,
   // bus release handshake
   input wire logic EXT_RELEASE_REQUEST,
   output logic BUS_RELEASED,
   output logic INTERNAL_NEED_BUS_OUT
);
   ebc_state_s st_q;
   ebc_state_s st_d;
   ebc_acc_dec_s dec;
   logic ext_acc;
   logic idle_now;
   logic rel_en;
   logic [2:0] rmts;

   // software standby leaves everything as it is
   logic unused_sw_standby;
   assign unused_sw_standby = SW_STANDBY;

   ebc_access_decode u_decode
   (
      .area(ACC_REQ.area),
      .internal(ACC_REQ.internal),
      .regs(st_q.regs),
      .dec(dec)
   );

   function automatic ebc_regs_s regs_reset();
      ebc_regs_s r;
      r.ast = `EBC_RST_AST;
      r.wait_ctrl_high = `EBC_RST_WCR;
      r.wait_ctrl_low = `EBC_RST_WCR;
      r.bus_ctrl_high = `EBC_RST_BUS_CTRL_HIGH;
      r.bus_ctrl_low = `EBC_RST_BUS_CTRL_LOW;
      return r;
   endfunction : regs_reset

   function automatic logic [7:0] reg_read(input ebc_regs_s r, input logic [`EBC_ADDR_W-1:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         `EBC_OFS_AST: v = r.ast;
         `EBC_OFS_WAIT_CTRL_HIGH: v = r.wait_ctrl_high;
         `EBC_OFS_WAIT_CTRL_LOW: v = r.wait_ctrl_low;
         `EBC_OFS_BUS_CTRL_HIGH: v = r.bus_ctrl_high;
         `EBC_OFS_BUS_CTRL_LOW: v = r.bus_ctrl_low;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : reg_read

   assign rmts = st_q.regs.bus_ctrl_high[`EBC_BUS_CTRL_HIGH_RMTS_HI:`EBC_BUS_CTRL_HIGH_RMTS_LO];
   assign rel_en = st_q.regs.bus_ctrl_low[`EBC_BUS_CTRL_LOW_REL_EN];
   assign ext_acc = ACC_REQ.valid && !ACC_REQ.internal;

   always_comb
   begin
      idle_now = 1'b0;
      if (ext_acc && st_q.last_valid && st_q.last_read)
      begin
         if (!ACC_REQ.write && (ACC_REQ.area != st_q.last_area)
             && st_q.regs.bus_ctrl_high[`EBC_BUS_CTRL_HIGH_IDLE_DIFF])
         begin
            idle_now = 1'b1;
         end
         if (ACC_REQ.write && st_q.regs.bus_ctrl_high[`EBC_BUS_CTRL_HIGH_IDLE_RW])
         begin
            idle_now = 1'b1;
         end
      end
   end

   always_comb
   begin
      st_d = st_q;

      // pin synchronisers
      st_d.stby_s1 = HW_STANDBY;
      st_d.stby_s2 = st_q.stby_s1;
      st_d.req_s1 = EXT_RELEASE_REQUEST;
      st_d.req_s2 = st_q.req_s1;

      // register writes
      if (st_q.stby_s2)
      begin
         st_d.regs = regs_reset();
      end
      else if (WR_EN)
      begin
         case (ADDR)
            `EBC_OFS_AST: st_d.regs.ast = WR_DATA;
            `EBC_OFS_WAIT_CTRL_HIGH: st_d.regs.wait_ctrl_high = WR_DATA;
            `EBC_OFS_WAIT_CTRL_LOW: st_d.regs.wait_ctrl_low = WR_DATA;
            `EBC_OFS_BUS_CTRL_HIGH: st_d.regs.bus_ctrl_high = WR_DATA;
            `EBC_OFS_BUS_CTRL_LOW: st_d.regs.bus_ctrl_low = WR_DATA;
            default: st_d.regs = st_q.regs;
         endcase
      end

      // read data stand only in the cycle after the strobe
      if (RD_EN)
      begin
         st_d.rd_data = reg_read(st_q.regs, ADDR);
      end
      else
      begin
         st_d.rd_data = 8'h00;
      end

      // per-access answer, one cycle after the query
      st_d.rsp = '0;
      if (ACC_REQ.valid)
      begin
         st_d.rsp.done = 1'b1;
         st_d.rsp.dec = dec;
         st_d.rsp.idle = idle_now;
      end

      // remember the last external cycle for idle insertion
      if (ext_acc)
      begin
         st_d.last_valid = 1'b1;
         st_d.last_read = !ACC_REQ.write;
         st_d.last_area = ACC_REQ.area;
      end

      // static configuration decode
      for (int a = 0; a < 8; a++)
      begin
         st_d.cfg.area_dram[a] = is_dram_area(rmts, 3'(a));
      end
      st_d.cfg.ram_type_undef = rmts[2];
      st_d.cfg.burst_rom_en = st_q.regs.bus_ctrl_high[`EBC_BUS_CTRL_HIGH_BROM];
      if (st_q.regs.bus_ctrl_high[`EBC_BUS_CTRL_HIGH_BLEN])
      begin
         st_d.cfg.burst_states = `EBC_BURST_2;
      end
      else
      begin
         st_d.cfg.burst_states = `EBC_BURST_1;
      end
      if (st_q.regs.bus_ctrl_high[`EBC_BUS_CTRL_HIGH_BWORDS])
      begin
         st_d.cfg.burst_words = `EBC_WORDS_8;
      end
      else
      begin
         st_d.cfg.burst_words = `EBC_WORDS_4;
      end
      st_d.cfg.low_column_strobe_used = (rmts != 3'h0) && !rmts[2];
      st_d.cfg.req_out_on_alt_pin = REQUEST_OUT_PIN_SELECT;
      st_d.cfg.release_pins_as_port = !rel_en;

      // bus release handshake
      if (!rel_en)
      begin
         st_d.released = 1'b0;
         st_d.need_bus = 1'b0;
      end
      else if (st_q.released)
      begin
         if (!st_q.req_s2)
         begin
            st_d.released = 1'b0;
            st_d.need_bus = 1'b0;
         end
         else if (ext_acc)
         begin
            st_d.need_bus = 1'b1;
         end
      end
      else if (st_q.req_s2 && !ACC_REQ.valid)
      begin
         st_d.released = 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         st_q <= '0;
         st_q.regs.ast <= `EBC_RST_AST;
         st_q.regs.wait_ctrl_high <= `EBC_RST_WCR;
         st_q.regs.wait_ctrl_low <= `EBC_RST_WCR;
         st_q.regs.bus_ctrl_high <= `EBC_RST_BUS_CTRL_HIGH;
         st_q.regs.bus_ctrl_low <= `EBC_RST_BUS_CTRL_LOW;
         st_q.cfg.burst_states <= `EBC_BURST_2;
         st_q.cfg.burst_words <= `EBC_WORDS_4;
         st_q.cfg.release_pins_as_port <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign RD_DATA = st_q.rd_data;
   assign ACC_RSP = st_q.rsp;
   assign CFG = st_q.cfg;
   assign BUS_RELEASED = st_q.released;
   assign INTERNAL_NEED_BUS_OUT = st_q.need_bus;
endmodule : ebc_area_config
`default_nettype wire

// ### design/ebc_params.svh
// offsets, field positions, reset values and counts of the external bus area configuration
`ifndef EBC_PARAMS_SVH
`define EBC_PARAMS_SVH
`define EBC_ADDR_W 3
`define EBC_OFS_AST 3'h0
`define EBC_OFS_WAIT_CTRL_HIGH 3'h1
`define EBC_OFS_WAIT_CTRL_LOW 3'h2
`define EBC_OFS_BUS_CTRL_HIGH 3'h3
`define EBC_OFS_BUS_CTRL_LOW 3'h4
`define EBC_RST_AST 8'hff
`define EBC_RST_WCR 8'hff
`define EBC_RST_BUS_CTRL_HIGH 8'hd0
`define EBC_RST_BUS_CTRL_LOW 8'h3c
`define EBC_BUS_CTRL_HIGH_IDLE_DIFF 7
`define EBC_BUS_CTRL_HIGH_IDLE_RW 6
`define EBC_BUS_CTRL_HIGH_BROM 5
`define EBC_BUS_CTRL_HIGH_BLEN 4
`define EBC_BUS_CTRL_HIGH_BWORDS 3
`define EBC_BUS_CTRL_HIGH_RMTS_HI 2
`define EBC_BUS_CTRL_HIGH_RMTS_LO 0
`define EBC_BUS_CTRL_LOW_REL_EN 7
`define EBC_STATES_INT 2'h0
`define EBC_STATES_2 2'h2
`define EBC_STATES_3 2'h3
`define EBC_BURST_1 2'h1
`define EBC_BURST_2 2'h2
`define EBC_WORDS_4 4'h4
`define EBC_WORDS_8 4'h8
`endif

// ### design/ebc_pkg.sv
// types shared by the external bus area configuration block
package ebc_pkg;
   typedef struct packed {
      logic valid;
      logic [2:0] area;
      logic internal;
      logic write;
   } ebc_acc_req_s;
   typedef struct packed {
      logic [1:0] states;
      logic [1:0] waits;
      logic dram;
      logic burst_rom;
   } ebc_acc_dec_s;
   typedef struct packed {
      logic done;
      logic idle;
      ebc_acc_dec_s dec;
   } ebc_acc_rsp_s;
   typedef struct packed {
      logic [7:0] area_dram;
      logic ram_type_undef;
      logic burst_rom_en;
      logic [1:0] burst_states;
      logic [3:0] burst_words;
      logic low_column_strobe_used;
      logic req_out_on_alt_pin;
      logic release_pins_as_port;
   } ebc_cfg_s;
   typedef struct packed {
      logic [7:0] ast;
      logic [7:0] wait_ctrl_high;
      logic [7:0] wait_ctrl_low;
      logic [7:0] bus_ctrl_high;
      logic [7:0] bus_ctrl_low;
   } ebc_regs_s;
   typedef struct packed {
      ebc_regs_s regs;
      logic [7:0] rd_data;
      ebc_acc_rsp_s rsp;
      ebc_cfg_s cfg;
      logic last_valid;
      logic last_read;
      logic [2:0] last_area;
      logic stby_s1;
      logic stby_s2;
      logic req_s1;
      logic req_s2;
      logic released;
      logic need_bus;
   } ebc_state_s;

   // areas 2..5 that the ram type code turns into dram space
   function automatic logic is_dram_area(input logic [2:0] rmts, input logic [2:0] area);
      logic hit;
      hit = 1'b0;
      case (rmts)
         3'h1: hit = (area == 3'h2);
         3'h2: hit = (area == 3'h2) || (area == 3'h3);
         3'h3: hit = (area >= 3'h2) && (area <= 3'h5);
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : is_dram_area
endpackage : ebc_pkg

// ### design/ebc_access_decode.sv
// per-access decode of states, program waits and interface type
`timescale 1ns/1ps
`default_nettype none
`include "ebc_params.svh"
module ebc_access_decode
   import ebc_pkg::*;
(
   // access being asked about
   input wire logic [2:0] area,
   input wire logic internal,
   // configuration registers
   input wire ebc_regs_s regs,
   // decode
   output ebc_acc_dec_s dec
);
   logic [1:0] wait_field;
   logic [15:0] wcr_all;
   logic [2:0] rmts;

   assign rmts = regs.bus_ctrl_high[`EBC_BUS_CTRL_HIGH_RMTS_HI:`EBC_BUS_CTRL_HIGH_RMTS_LO];

   always_comb
   begin
      wcr_all = {regs.wait_ctrl_high, regs.wait_ctrl_low};
      // area n lives in bit pair 2n+1:2n of the joined pair
      wait_field = wcr_all[{area, 1'b0} +: 2];
      dec = '0;
      if (internal)
      begin
         dec.states = `EBC_STATES_INT;
         dec.waits = 2'h0;
      end
      else if (regs.ast[area])
      begin
         dec.states = `EBC_STATES_3;
         dec.waits = wait_field;
      end
      else
      begin
         dec.states = `EBC_STATES_2;
         dec.waits = 2'h0;
      end
      dec.dram = !internal && is_dram_area(rmts, area);
      dec.burst_rom = !internal && (area == 3'h0) && regs.bus_ctrl_high[`EBC_BUS_CTRL_HIGH_BROM];
   end
endmodule : ebc_access_decode
`default_nettype wire

// ### verif/ebc_area_config_monitor.sv
// port assertions of the area configuration block
`timescale 1ns/1ps
`default_nettype none
module ebc_area_config_monitor
   import ebc_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // register port
   input wire logic RD_EN,
   input wire logic [7:0] RD_DATA,
   // access query and configuration
   input wire ebc_acc_req_s ACC_REQ,
   input wire ebc_acc_rsp_s ACC_RSP,
   input wire ebc_cfg_s CFG,
   // release handshake
   input wire logic EXT_RELEASE_REQUEST,
   input wire logic BUS_RELEASED,
   input wire logic INTERNAL_NEED_BUS_OUT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   property p_done; ACC_REQ.valid |=> ACC_RSP.done; endproperty
   property p_int; ACC_REQ.valid && ACC_REQ.internal |=> ACC_RSP.dec.states == 2'h0 && ACC_RSP.dec.waits == 2'h0;
   endproperty
   property p_two; ACC_RSP.done && ACC_RSP.dec.states == 2'h2 |-> ACC_RSP.dec.waits == 2'h0; endproperty
   property p_rd; !RD_EN |=> RD_DATA == 8'h00; endproperty
   property p_burst; CFG.burst_states inside {2'h1, 2'h2} && CFG.burst_words inside {4'h4, 4'h8}; endproperty
   property p_dram; (CFG.area_dram & 8'hc3) == 8'h00 && (!CFG.ram_type_undef || CFG.area_dram == 8'h00); endproperty
   property p_refuse; CFG.release_pins_as_port |-> !BUS_RELEASED; endproperty
   property p_ack; $rose(BUS_RELEASED) |-> $past(EXT_RELEASE_REQUEST, 3); endproperty
   property p_need; $rose(INTERNAL_NEED_BUS_OUT) |-> BUS_RELEASED && $past(ACC_REQ.valid) && !$past(ACC_REQ.internal);
   endproperty
   a_done: assert property (p_done) else $error("no answer to access query");
   a_int: assert property (p_int) else $error("internal access got waits");
   a_two: assert property (p_two) else $error("waits in two-state space");
   a_rd: assert property (p_rd) else $error("read data outside read slot");
   a_burst: assert property (p_burst) else $error("burst length or word limit off");
   a_dram: assert property (p_dram) else $error("dram outside areas 2 to 5");
   a_refuse: assert property (p_refuse) else $error("bus released while disabled");
   a_ack: assert property (p_ack) else $error("release without request");
   a_need: assert property (p_need) else $error("request output without cause");
   c_idle: cover property (ACC_RSP.idle);
   c_rel: cover property ($rose(BUS_RELEASED));
   c_need: cover property ($rose(INTERNAL_NEED_BUS_OUT));
endmodule : ebc_area_config_monitor
bind ebc_area_config ebc_area_config_monitor i_ebc_area_config_monitor (.CLK(CLK), .RST(RST), .RD_EN(RD_EN),
   .RD_DATA(RD_DATA), .ACC_REQ(ACC_REQ), .ACC_RSP(ACC_RSP), .CFG(CFG), .EXT_RELEASE_REQUEST(EXT_RELEASE_REQUEST),
   .BUS_RELEASED(BUS_RELEASED), .INTERNAL_NEED_BUS_OUT(INTERNAL_NEED_BUS_OUT));
`default_nettype wire

// ### verif/ebc_ext_master.sv
// external master that asks for the bus and backs off
`timescale 1ns/1ps
`default_nettype none
module ebc_ext_master
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bench control
   input wire logic want,
   input wire logic [1:0] lag,
   // handshake
   input wire logic released,
   input wire logic need,
   output logic req
);
   logic [1:0] cnt_q;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 2'h0;
         req <= 1'b0;
      end
      else
      begin
         cnt_q <= (released && need) ? ((cnt_q == lag) ? cnt_q : cnt_q + 2'h1) : 2'h0;
         req <= want && !(released && need && cnt_q == lag);
      end
   end
endmodule : ebc_ext_master
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench of the area configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ebc_pkg::*;
;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic HW_STANDBY = 1'b0;
   logic SW_STANDBY = 1'b0;
   logic WR_EN = 1'b0;
   logic RD_EN = 1'b0;
   logic PSEL = 1'b0;
   logic want = 1'b0;
   logic [1:0] lag = 2'h0;
   logic [2:0] ADDR = 3'h0;
   logic [7:0] WR_DATA = 8'h00;
   ebc_acc_req_s ACC_REQ = '0;
   logic [7:0] RD_DATA;
   ebc_acc_rsp_s ACC_RSP;
   ebc_cfg_s CFG;
   logic REQ, BUS_RELEASED, NEED;
   logic [7:0] shadow [0:4] = '{8'hff, 8'hff, 8'hff, 8'hd0, 8'h3c};
   logic last_rd = 1'b0;
   logic [2:0] last_area = 3'h0;
   int num_errors = 0;
   int tests_run = 0;
   ebc_area_config i_ebc_area_config (.CLK(CLK), .RST(RST), .HW_STANDBY(HW_STANDBY), .SW_STANDBY(SW_STANDBY),
      .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .ACC_REQ(ACC_REQ),
      .ACC_RSP(ACC_RSP), .REQUEST_OUT_PIN_SELECT(PSEL), .CFG(CFG), .EXT_RELEASE_REQUEST(REQ),
      .BUS_RELEASED(BUS_RELEASED), .INTERNAL_NEED_BUS_OUT(NEED));
   ebc_ext_master i_ebc_ext_master (.clk(CLK), .rst(RST), .want(want), .lag(lag), .released(BUS_RELEASED),
      .need(NEED), .req(REQ));
   initial forever #5 CLK = ~CLK;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WR_DATA <= d;
      WR_EN <= 1'b1;
      @(posedge CLK);
      WR_EN <= 1'b0;
      if (a < 3'h5) shadow[a] = d;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge CLK);
      ADDR <= a;
      RD_EN <= 1'b1;
      @(posedge CLK);
      RD_EN <= 1'b0;
      #1 v = RD_DATA;
   endtask : rd
   function automatic logic is_dr(input logic [2:0] rm, input logic [2:0] ar);
      return (rm == 3'h1 && ar == 3'h2) || (rm == 3'h2 && (ar == 3'h2 || ar == 3'h3))
         || (rm == 3'h3 && ar >= 3'h2 && ar <= 3'h5);
   endfunction : is_dr
   function automatic logic [7:0] dmask(input logic [2:0] rm);
      for (int i = 0; i < 8; i++) dmask[i] = is_dr(rm, i[2:0]);
   endfunction : dmask
   function automatic logic [7:0] exp_rsp(input logic [2:0] ar, input logic w);
      logic [7:0] wc;
      logic t3;
      wc = ar[2] ? shadow[1] : shadow[2];
      t3 = shadow[0][ar];
      return {1'b1, last_rd && (w ? shadow[3][6] : (ar != last_area && shadow[3][7])), t3 ? 2'h3 : 2'h2,
         t3 ? wc[{ar[1:0], 1'b0} +: 2] : 2'h0, is_dr(shadow[3][2:0], ar), ar == 3'h0 && shadow[3][5]};
   endfunction : exp_rsp
   task automatic acc(input logic [2:0] ar, input logic it, input logic w);
      logic [7:0] e;
      e = exp_rsp(ar, w);
      @(posedge CLK);
      ACC_REQ <= {1'b1, ar, it, w};
      @(posedge CLK);
      ACC_REQ <= '0;
      #1;
      if (it)
         chk(ACC_RSP, 8'h80);
      else
         chk(ACC_RSP, e);
      last_rd = it ? last_rd : !w;
      last_area = it ? last_area : ar;
   endtask : acc
   task automatic wait_rel(input logic v);
      int n;
      n = 0;
      while (BUS_RELEASED !== v && n < 10)
      begin
         @(posedge CLK);
         #1 n++;
      end
      chk({7'h0, BUS_RELEASED}, {7'h0, v});
   endtask : wait_rel
   task automatic read_all();
      logic [7:0] v;
      for (int i = 0; i < 8; i++)
      begin
         rd(i[2:0], v);
         chk(v, i < 5 ? shadow[i] : 8'h00);
      end
   endtask : read_all
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   initial
   begin
      repeat (5000) @(posedge CLK);
      num_errors++;
      stop_test();
   end
   initial
   begin
      logic [2:0] a;
      logic [7:0] ev;
      void'($urandom(32'ha4d5));
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      read_all();
      $display("test reset values done");
      repeat (30)
      begin
         a = 3'($urandom_range(7));
         SW_STANDBY <= 1'($urandom);
         PSEL <= 1'($urandom);
         wr(a, 8'($urandom));
         rd(a, ev);
         chk(ev, a < 3'h5 ? shadow[a] : 8'h00);
      end
      $display("test register access done");
      repeat (12)
      begin
         PSEL <= 1'($urandom);
         for (int r = 0; r < 4; r++)
            wr(r[2:0], 8'($urandom));
         @(posedge CLK);
         ev = {shadow[3][5], shadow[3][4] ? 2'h2 : 2'h1, shadow[3][3] ? 4'h8 : 4'h4, 1'b0};
         #1 chk({CFG.burst_rom_en, CFG.burst_states, CFG.burst_words, 1'b0}, ev);
         chk(CFG.area_dram, dmask(shadow[3][2:0]));
         ev = {CFG.ram_type_undef, CFG.low_column_strobe_used, CFG.req_out_on_alt_pin, CFG.release_pins_as_port, 4'h0};
         chk(ev, {shadow[3][2], |dmask(shadow[3][2:0]), PSEL, !shadow[4][7], 4'h0});
         repeat (16)
            acc(3'($urandom), $urandom_range(3) == 0, 1'($urandom));
      end
      $display("test access decode done");
      wr(3'h4, 8'h3c);
      want <= 1'b1;
      repeat (10) @(posedge CLK);
      #1 chk({7'h0, BUS_RELEASED}, 8'h00);
      wr(3'h4, 8'hbc);
      wait_rel(1'b1);
      lag <= 2'($urandom);
      acc(3'h1, 1'b0, 1'b0);
      chk({7'h0, NEED}, 8'h01);
      wait_rel(1'b0);
      want <= 1'b0;
      chk({7'h0, NEED}, 8'h00);
      $display("test bus release done");
      @(posedge CLK);
      HW_STANDBY <= 1'b1;
      @(posedge CLK);
      HW_STANDBY <= 1'b0;
      repeat (4) @(posedge CLK);
      shadow = '{8'hff, 8'hff, 8'hff, 8'hd0, 8'h3c};
      read_all();
      $display("test hardware standby done");
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
